// *** wcc_pkg.sv ***
// Package for the wetting-current configuration register block.
// Assumes a single 200 MHz clock domain and an internal register access port.
package wcc_pkg;

    localparam int          WCC_DATA_W        = 24;
    localparam int          WCC_ADDR_W        = 6;
    localparam logic [5:0]  WCC_OFS_LEVEL     = 6'h1E;
    localparam logic [5:0]  WCC_OFS_PULSE     = 6'h1F;
    localparam logic [23:0] WCC_RST_LEVEL     = 24'h000000;
    localparam logic [23:0] WCC_RST_PULSE     = 24'h000000;
    localparam logic [23:0] WCC_MASK_LEVEL    = 24'h7FFFFF;
    localparam logic [23:0] WCC_MASK_PULSE    = 24'h00007F;

    // Level register layout
    localparam int          WCC_POS_SINK_DIS  = 22;
    localparam int          WCC_POS_SRC_DIS   = 21;
    localparam int          WCC_POS_IN23      = 18;
    localparam int          WCC_POS_IN22      = 15;
    localparam int          WCC_POS_PAIR20    = 12;
    localparam int          WCC_POS_PAIR18    = 9;
    localparam int          WCC_POS_PAIR16    = 6;
    localparam int          WCC_POS_PAIR14    = 3;
    localparam int          WCC_POS_PAIR12    = 0;

    // Pulse register layout
    localparam int          WCC_POS_DURATION  = 4;
    localparam int          WCC_POS_GROUP3    = 3;
    localparam int          WCC_POS_GROUP2    = 2;
    localparam int          WCC_POS_GROUP1    = 1;
    localparam int          WCC_POS_GROUP0    = 0;

    // Level codes
    localparam logic [2:0]  WCC_CODE_OFF      = 3'h0;
    localparam logic [2:0]  WCC_CODE_1MA      = 3'h1;
    localparam logic [2:0]  WCC_CODE_2MA      = 3'h2;
    localparam logic [2:0]  WCC_CODE_5MA      = 3'h3;
    localparam logic [2:0]  WCC_CODE_10MA     = 3'h4;

    // Pulse timing
    localparam int          WCC_CLK_MHZ       = 200;
    localparam int          WCC_PULSE_STEP_US = 64;
    localparam int          WCC_PULSE_STEP_CYC = WCC_PULSE_STEP_US * WCC_CLK_MHZ;

    typedef enum logic [2:0] {
        WCC_I_OFF  = 3'h0,
        WCC_I_1MA  = 3'h1,
        WCC_I_2MA  = 3'h2,
        WCC_I_5MA  = 3'h3,
        WCC_I_10MA = 3'h4,
        WCC_I_15MA = 3'h5
    } wcc_current_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [5:0]            addr;
        logic [23:0]           wdata;
    } wcc_req_t;

endpackage : wcc_pkg

// *** wcc_level_decode.sv ***
// Decodes one 3-bit level field into a current, applying closure scaling.
// Assumes switch-closed and sink/source select come from same-clock logic.
`timescale 1ns/1ps
module wcc_level_decode
    import wcc_pkg::*;
(
    input  wire logic [2:0]   code,
    input  wire logic         closed,
    input  wire logic         is_sink,
    input  wire logic         continuous,
    input  wire logic         sink_dis,
    input  wire logic         src_dis,
    output wcc_current_t      current
);
    wcc_current_t base;
    logic         scale_off;

    always_comb begin
        unique case (code)
            WCC_CODE_OFF:  base = WCC_I_OFF;
            WCC_CODE_1MA:  base = WCC_I_1MA;
            WCC_CODE_2MA:  base = WCC_I_2MA;
            WCC_CODE_5MA:  base = WCC_I_5MA;
            WCC_CODE_10MA: base = WCC_I_10MA;
            default:       base = WCC_I_15MA;
        endcase
    end

    // Sink when select is one, source when zero
    assign scale_off = is_sink ? sink_dis : src_dis;

    always_comb begin
        if (continuous && closed && !scale_off &&
            (base == WCC_I_10MA || base == WCC_I_15MA)) begin
            current = WCC_I_2MA;
        end else begin
            current = base;
        end
    end
endmodule : wcc_level_decode

// *** wcc_config_regs.sv ***
// Wetting-current configuration registers for inputs 12..23 and pulsed cleaning.
// Assumes the serial framing logic presents decoded one-cycle read/write strobes
// and that switch state, source/sink select and pulse enables are same-clock.
// Registers take whole 24-bit words only; there are no byte lanes.
`timescale 1ns/1ps
module wcc_config_regs
    import wcc_pkg::*;
#(
    parameter int STEP_CYC = WCC_PULSE_STEP_CYC
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    // Register access
    input  wire wcc_req_t     req,
    output logic [23:0]       rdata,
    output logic              rvalid,
    // Switch state, mode and enables
    input  wire logic         continuous,
    input  wire logic [11:0]  switch_closed,
    input  wire logic [11:0]  current_source,
    input  wire logic [23:0]  pulse_enable_per_input,
    input  wire logic         pulse_start,
    // Current control and register view
    output wcc_current_t      level_current [12],
    output logic [23:0]       pulse_active,
    output logic [3:0]        pulse_level_15ma,
    output logic [23:0]       level_reg,
    output logic [23:0]       pulse_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic        sel_level;
    logic        sel_pulse;

    assign sel_level = (req.addr == WCC_OFS_LEVEL);
    assign sel_pulse = (req.addr == WCC_OFS_PULSE);

    logic [23:0] next_level;
    logic [23:0] next_pulse;
    logic [23:0] next_rdata;

    // Reserved bits dropped on the way in, so they never read back
    always_comb begin
        next_level = level_reg;
        next_pulse = pulse_reg;
        if (req.wr && sel_level) begin
            next_level = req.wdata & WCC_MASK_LEVEL;
        end
        if (req.wr && sel_pulse) begin
            next_pulse = req.wdata & WCC_MASK_PULSE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_reg <= WCC_RST_LEVEL;
        end else begin
            level_reg <= next_level;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_reg <= WCC_RST_PULSE;
        end else begin
            pulse_reg <= next_pulse;
        end
    end

    // Unmapped offsets read zero
    always_comb begin
        if (sel_level) begin
            next_rdata = level_reg;
        end else if (sel_pulse) begin
            next_rdata = pulse_reg;
        end else begin
            next_rdata = 24'h000000;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // Held between reads for a slow framer to shift out
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 24'h000000;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Level decode with continuous-mode scaling, one per input 12..23

    logic       sink_dis;
    logic       src_dis;
    logic [2:0] field_of [12];

    assign sink_dis = level_reg[WCC_POS_SINK_DIS];
    assign src_dis  = level_reg[WCC_POS_SRC_DIS];

    // Pairs 12/13..20/21 share a field; 22 and 23 own theirs
    always_comb begin
        field_of[0]  = level_reg[WCC_POS_PAIR12 +: 3];
        field_of[1]  = level_reg[WCC_POS_PAIR12 +: 3];
        field_of[2]  = level_reg[WCC_POS_PAIR14 +: 3];
        field_of[3]  = level_reg[WCC_POS_PAIR14 +: 3];
        field_of[4]  = level_reg[WCC_POS_PAIR16 +: 3];
        field_of[5]  = level_reg[WCC_POS_PAIR16 +: 3];
        field_of[6]  = level_reg[WCC_POS_PAIR18 +: 3];
        field_of[7]  = level_reg[WCC_POS_PAIR18 +: 3];
        field_of[8]  = level_reg[WCC_POS_PAIR20 +: 3];
        field_of[9]  = level_reg[WCC_POS_PAIR20 +: 3];
        field_of[10] = level_reg[WCC_POS_IN22 +: 3];
        field_of[11] = level_reg[WCC_POS_IN23 +: 3];
    end

    // One decoder per input, since each has its own select and switch
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_in
            wcc_level_decode u_dec (
                .code       (field_of[gi]),
                .closed     (switch_closed[gi]),
                .is_sink    (current_source[gi]),
                .continuous (continuous),
                .sink_dis   (sink_dis),
                .src_dis    (src_dis),
                .current    (level_current[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pulsed cleaning timer

    logic [2:0]  pulse_duration_field;
    logic [15:0] step_cnt;
    logic [2:0]  step_idx;
    logic        running;

    assign pulse_duration_field = pulse_reg[WCC_POS_DURATION +: 3];
    assign pulse_level_15ma = {pulse_reg[WCC_POS_GROUP3],
                               pulse_reg[WCC_POS_GROUP2],
                               pulse_reg[WCC_POS_GROUP1],
                               pulse_reg[WCC_POS_GROUP0]};

    logic        step_done;
    logic        last_step;

    assign step_done = running && (step_cnt == 16'(STEP_CYC - 1));
    // Duration read live, so a rewrite shortens or extends the pulse
    assign last_step = step_done && (step_idx >= pulse_duration_field);

    // A start request while running is ignored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            running <= 1'b0;
        end else if (!running) begin
            running <= pulse_start;
        end else if (last_step) begin
            running <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_cnt <= 16'h0000;
        end else if (!running || step_done) begin
            step_cnt <= 16'h0000;
        end else begin
            step_cnt <= step_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_idx <= 3'h0;
        end else if (!running) begin
            step_idx <= 3'h0;
        end else if (step_done && !last_step) begin
            step_idx <= step_idx + 3'h1;
        end
    end

    // Enables pass through, registered, for as many cycles as the timer runs, one cycle behind it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_active <= 24'h000000;
        end else begin
            pulse_active <= running ? pulse_enable_per_input : 24'h000000;
        end
    end

endmodule : wcc_config_regs

// *** wcc_chk.sv ***
// Port assertions for the wetting-current config register block.
// Assumes one clock domain; bound into every instance below.
`timescale 1ns/1ps
module wcc_chk
    import wcc_pkg::*;
#(parameter int STEP_CYC = 4)(
    input wire logic         clk,
    input wire logic         rstn,
    input wire wcc_req_t     req,
    input wire logic [23:0]  rdata,
    input wire logic         rvalid,
    input wire logic         continuous,
    input wire logic [11:0]  switch_closed,
    input wire logic [11:0]  current_source,
    input wire logic [23:0]  pulse_enable_per_input,
    input wire wcc_current_t level_current [12],
    input wire logic [23:0]  pulse_active,
    input wire logic [3:0]   pulse_level_15ma,
    input wire logic [23:0]  level_reg,
    input wire logic [23:0]  pulse_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wr_level_a: assert property (
        req.wr && req.addr == WCC_OFS_LEVEL |=> level_reg == ($past(req.wdata) & 24'h7FFFFF)
    ) else $error("level write lost");
    wr_pulse_a: assert property (
        req.wr && req.addr == WCC_OFS_PULSE |=> pulse_reg == ($past(req.wdata) & 24'h00007F)
    ) else $error("pulse write lost");
    rd_data_a: assert property (
        req.rd |=> rvalid && rdata == ($past(req.addr) == WCC_OFS_LEVEL ? $past(level_reg)
            : $past(req.addr) == WCC_OFS_PULSE ? $past(pulse_reg) : 24'h0)
    ) else $error("bad read data");
    rsvd_zero_a: assert property (
        !level_reg[23] && pulse_reg[23:7] == 17'h0
    ) else $error("reserved bit set");
    group_bits_a: assert property (
        pulse_level_15ma == pulse_reg[3:0]
    ) else $error("group level wrong");
    code_map_a: assert property (
        !continuous |-> level_current[10] == (level_reg[17:15] > 3'h4 ? WCC_I_15MA
            : wcc_current_t'(level_reg[17:15]))
    ) else $error("level decode wrong");
    scale_down_a: assert property (
        continuous && switch_closed[11] && level_reg[20:18] >= 3'h4
            && !(current_source[11] ? level_reg[22] : level_reg[21]) |-> level_current[11] == WCC_I_2MA
    ) else $error("no scaling");
    pulse_mask_a: assert property (
        (pulse_active & ~$past(pulse_enable_per_input)) == 24'h0
    ) else $error("pulse on disabled input");
    cover property (req.wr);
    cover property (rvalid);
    cover property ($rose(|pulse_active));
endmodule : wcc_chk

bind wcc_config_regs wcc_chk #(.STEP_CYC(STEP_CYC)) chk_u (.*);

// *** wcc_host.sv ***
// Host model: issues one-cycle register strobes.
// Assumes requests are serialised by the caller.
`timescale 1ns/1ps
module wcc_host
    import wcc_pkg::*;
(
    input  wire logic clk,
    output wcc_req_t  req
);
    initial req = '0;
    // Whole words only, never partial
    task automatic xfer(logic w, logic [5:0] a, logic [23:0] d);
        @(posedge clk);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '0;
    endtask : xfer
endmodule : wcc_host

// *** tb_wetting_current_config_regs.sv ***
// Self-checking bench for the wetting-current config registers.
// Assumes the host model and a short pulse step of 4 cycles.
`timescale 1ns/1ps
module tb_wetting_current_config_regs
    import wcc_pkg::*;
;
    localparam int STEP = 4;
    logic         clk = 0, rstn = 0, continuous = 0, pulse_start = 0, rvalid;
    logic [11:0]  switch_closed = '0, current_source = '0;
    logic [23:0]  pulse_enable_per_input = '0, rdata, pulse_active, level_reg, pulse_reg;
    logic [3:0]   pulse_level_15ma;
    logic [23:0]  mdl [2] = '{default: '0};
    logic [31:0]  rnd = 32'h779A;
    wcc_req_t     req;
    wcc_current_t level_current [12];
    int           bad_count = 0, cmp_count = 0, n;
    wcc_host host_u (.clk(clk), .req(req));
    wcc_config_regs #(.STEP_CYC(STEP)) dut_u (.*);
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic wcc_current_t exp_cur(int i, logic [23:0] r, logic cn, cl, sk);
        int p;
        logic [2:0] c;
        p = i < 10 ? (i / 2) * 3 : i * 3 - 15;
        c = r[p +: 3];
        if (c >= 3'h4 && cn && cl && !(sk ? r[22] : r[21]))
            return WCC_I_2MA;
        return c > 3'h4 ? WCC_I_15MA : wcc_current_t'(c);
    endfunction : exp_cur
    task automatic chk24(logic [23:0] got, logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk24
    task automatic chkc(wcc_current_t got, wcc_current_t exp);
        chk24({21'h0, got}, {21'h0, exp});
    endtask : chkc
    task automatic wr(logic [5:0] a, logic [23:0] d);
        host_u.xfer(1'b1, a, d);
        if (a == WCC_OFS_LEVEL) mdl[0] = d & 24'h7FFFFF;
        if (a == WCC_OFS_PULSE) mdl[1] = d & 24'h00007F;
    endtask : wr
    task automatic rd(logic [5:0] a, logic [23:0] exp);
        host_u.xfer(1'b0, a, 24'h0);
        #1 chk24({23'h0, rvalid}, 24'h1);
        chk24(rdata, exp);
    endtask : rd
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(WCC_OFS_LEVEL, 24'h0);
        rd(WCC_OFS_PULSE, 24'h0);
        // Level reserved bit 23 forced high, pulse reserved bits left random; 0x20 is outside this block
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(WCC_OFS_LEVEL, rnd[23:0] | 24'h800000);
            wr(6'h20, rnd[31:8]);
            wr(WCC_OFS_PULSE, rnd[31:8]);
            rd(WCC_OFS_LEVEL, mdl[0]);
            rd(WCC_OFS_PULSE, mdl[1]);
            rd(6'h20, 24'h0);
        end
        for (int c = 0; c < 64; c++) begin
            rnd = lfsr(rnd);
            wr(WCC_OFS_LEVEL, {1'b0, rnd[1:0], {7{c[2:0]}}});
            continuous <= c[3];
            switch_closed <= rnd[13:2];
            current_source <= rnd[25:14];
            @(posedge clk);
            #1;
            for (int i = 0; i < 12; i++)
                chkc(level_current[i], exp_cur(i, mdl[0], continuous, switch_closed[i],
                    current_source[i]));
        end
        for (int d = 0; d < 8; d++) begin
            rnd = lfsr(rnd);
            wr(WCC_OFS_PULSE, {17'h0, d[2:0], rnd[27:24]});
            pulse_enable_per_input <= rnd[23:0] | 24'h1;
            @(posedge clk);
            pulse_start <= 1'b1;
            #1 chk24({20'h0, pulse_level_15ma}, {20'h0, mdl[1][3:0]});
            n = 0;
            repeat (40) begin
                @(posedge clk);
                pulse_start <= 1'b0;
                #1 n += int'(pulse_active === pulse_enable_per_input);
            end
            chk24(24'(n), 24'((d + 1) * STEP));
        end
        print_verdict();
    end
endmodule : tb_wetting_current_config_regs
